// >>> logic/key_irq_defines.svh
// Register offsets, field positions, reset values and sizes for the keyboard interrupt block
`ifndef KEY_IRQ_DEFINES_SVH
`define KEY_IRQ_DEFINES_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define KEY_ADDR_W 4
`define KEY_STATUS_CONTROL_OFS 4'h0
`define KEY_PIN_ENABLE_OFS 4'h1
`define PORT_A_PULLUP_OFS 4'h2
`define KEY_PIN_LEVEL_OFS 4'h3

// ----------------------------------------------------------------------
// Fields of the status and control register
// ----------------------------------------------------------------------
`define KSC_MODE_BIT 0
`define KSC_MASK_BIT 1
`define KSC_ACK_BIT 2
`define KSC_REQ_BIT 3

// ----------------------------------------------------------------------
// Reset values and sizes
// ----------------------------------------------------------------------
`define KEY_PINS_DEFAULT 7
`define KEY_ENABLE_RESET 8'h00
`define KEY_PULLUP_RESET 8'h00
`define KEY_DATA_W 8

`endif

// >>> logic/key_irq_pkg.sv
// Types shared by the keyboard interrupt block
`default_nettype none
package key_irq_pkg;
  typedef enum logic [1:0] {
    TRIG_IDLE,
    TRIG_LATCHED,
    TRIG_HOLD
  } trig_state_type;
  typedef enum logic {
    MODE_EDGE,
    MODE_EDGE_LEVEL
  } trig_mode_type;
endpackage : key_irq_pkg
`default_nettype wire

// >>> logic/key_sync_if.sv
// Synchronised pin levels passed from the pin synchroniser to the detector
`timescale 1ns/100ps
`default_nettype none
interface key_sync_if #(parameter int PINS = 7);
  logic [PINS-1:0] level;
  modport source (output level);
  modport sink (input level);
endinterface : key_sync_if
`default_nettype wire

// >>> logic/key_pin_sync.sv
// Two flip-flop synchroniser for the keyboard pins
`timescale 1ns/100ps
`default_nettype none
module key_pin_sync #(
  parameter int PINS = 7
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [PINS-1:0] pins_in,
  key_sync_if.source sync_out
);
  // Resets high so idle pulled-up pins never look like a press
  logic [PINS-1:0] meta_ff;
  logic [PINS-1:0] stable_ff;

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      meta_ff <= '1;
      stable_ff <= '1;
    end else begin
      meta_ff <= pins_in;
      stable_ff <= meta_ff;
    end
  end

  assign sync_out.level = stable_ff;
endmodule : key_pin_sync
`default_nettype wire

// >>> logic/key_pin_irq.sv
// Keyboard pin interrupt: pin enables, pull-ups, trigger and acknowledge
`include "key_irq_defines.svh"
`timescale 1ns/100ps
`default_nettype none
module key_pin_irq #(
  parameter int PINS = `KEY_PINS_DEFAULT
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [`KEY_ADDR_W-1:0] addr_in,
  input wire logic [`KEY_DATA_W-1:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [`KEY_DATA_W-1:0] rdata_out,
  input wire logic [PINS-1:0] key_pins_in,
  input wire logic vector_fetch_in,
  output logic [PINS-1:0] pullup_on_out,
  output logic key_irq_out
);

  // ----------------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------------
  if (PINS < 1 || PINS > `KEY_DATA_W) begin : g_bad_pins
    $error("PINS must lie between 1 and the data width");
  end

  if (`KSC_REQ_BIT >= `KEY_DATA_W) begin : g_bad_fields
    $error("status fields must fit the data word");
  end

  // ----------------------------------------------------------------------
  // Pin synchroniser
  // ----------------------------------------------------------------------
  key_sync_if #(.PINS(PINS)) sync_bus ();

  key_pin_sync #(.PINS(PINS)) u_sync (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .pins_in(key_pins_in),
    .sync_out(sync_bus.source)
  );

  // ----------------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------------
  function automatic logic hit(input logic [`KEY_ADDR_W-1:0] a,
                               input logic [`KEY_ADDR_W-1:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  wire wr_ctl = wr_in && hit(addr_in, `KEY_STATUS_CONTROL_OFS);
  wire wr_en = wr_in && hit(addr_in, `KEY_PIN_ENABLE_OFS);
  wire wr_pu = wr_in && hit(addr_in, `PORT_A_PULLUP_OFS);

  logic [PINS-1:0] key_pin_enable_ff;
  logic [PINS-1:0] port_pullup_enable_ff;
  key_irq_pkg::trig_mode_type trigger_mode_select_ff;
  logic key_irq_mask_ff;
  key_irq_pkg::trig_state_type state_ff;
  key_irq_pkg::trig_state_type nxt_state;
  logic all_high_ff;
  logic [`KEY_DATA_W-1:0] rdata_ff;

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      key_pin_enable_ff <= PINS'(`KEY_ENABLE_RESET);
      port_pullup_enable_ff <= PINS'(`KEY_PULLUP_RESET);
      trigger_mode_select_ff <= key_irq_pkg::MODE_EDGE;
      key_irq_mask_ff <= 1'b0;
    end else begin
      if (wr_en) begin
        key_pin_enable_ff <= wdata_in[PINS-1:0];
      end
      if (wr_pu) begin
        port_pullup_enable_ff <= wdata_in[PINS-1:0];
      end
      if (wr_ctl) begin
        trigger_mode_select_ff <=
          key_irq_pkg::trig_mode_type'(wdata_in[`KSC_MODE_BIT]);
        key_irq_mask_ff <= wdata_in[`KSC_MASK_BIT];
      end
    end
  end

  // Enabling a key pin overrides the general pull-up setting
  assign pullup_on_out = port_pullup_enable_ff | key_pin_enable_ff;

  // ----------------------------------------------------------------------
  // Trigger detection
  // ----------------------------------------------------------------------
  wire [PINS-1:0] sync_level = sync_bus.level;
  // Disabled pins read as high so they never hold off or raise a request
  wire [PINS-1:0] eff_level = sync_level | ~key_pin_enable_ff;
  wire any_low = ~&eff_level;
  wire level_mode = (trigger_mode_select_ff == key_irq_pkg::MODE_EDGE_LEVEL);
  // Fall seen only from the all-high condition
  wire fall_event = all_high_ff && any_low;
  wire ack_wr = wr_ctl && wdata_in[`KSC_ACK_BIT];
  wire ack = ack_wr || vector_fetch_in;

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      all_high_ff <= 1'b1;
    end else begin
      all_high_ff <= ~any_low;
    end
  end

  // ----------------------------------------------------------------------
  // Request state
  // ----------------------------------------------------------------------
  // LATCHED: request pending. HOLD: acknowledged in level mode, pins still low
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      key_irq_pkg::TRIG_IDLE: begin
        if (fall_event) begin
          nxt_state = key_irq_pkg::TRIG_LATCHED;
        end
      end
      key_irq_pkg::TRIG_LATCHED: begin
        if (ack) begin
          if (level_mode && any_low) begin
            nxt_state = key_irq_pkg::TRIG_HOLD;
          end else begin
            nxt_state = key_irq_pkg::TRIG_IDLE;
          end
        end
      end
      key_irq_pkg::TRIG_HOLD: begin
        if (!level_mode || !any_low) begin
          nxt_state = key_irq_pkg::TRIG_IDLE;
        end
      end
      default: nxt_state = key_irq_pkg::TRIG_IDLE;
    endcase
    // A new fall in the acknowledge cycle wins over the clear
    if (fall_event) begin
      nxt_state = key_irq_pkg::TRIG_LATCHED;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      state_ff <= key_irq_pkg::TRIG_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Request stays up while held in level mode and any enabled pin is low
  wire request = (state_ff != key_irq_pkg::TRIG_IDLE);
  assign key_irq_out = request && !key_irq_mask_ff;

  // ----------------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------------
  logic [`KEY_DATA_W-1:0] rd_mux;
  always_comb begin
    rd_mux = '0;
    case (addr_in)
      `KEY_STATUS_CONTROL_OFS: begin
        rd_mux[`KSC_MODE_BIT] = level_mode;
        rd_mux[`KSC_MASK_BIT] = key_irq_mask_ff;
        rd_mux[`KSC_REQ_BIT] = request;
      end
      `KEY_PIN_ENABLE_OFS: rd_mux[PINS-1:0] = key_pin_enable_ff;
      `PORT_A_PULLUP_OFS: rd_mux[PINS-1:0] = port_pullup_enable_ff;
      `KEY_PIN_LEVEL_OFS: rd_mux[PINS-1:0] = sync_level;
      default: rd_mux = '0;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      rdata_ff <= '0;
    end else begin
      rdata_ff <= rd_in ? rd_mux : '0;
    end
  end
  assign rdata_out = rdata_ff;

  // ----------------------------------------------------------------------
  // Assertion helper
  // ----------------------------------------------------------------------
  // Remembers an acknowledge since the last latch, so a request that ends
  // without one is caught however long after the latch it ends
  logic acked_ff;

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      acked_ff <= 1'b0;
    end else begin
      // A fresh fall starts a new, unacknowledged request
      acked_ff <= fall_event ? 1'b0 : (acked_ff | ack);
    end
  end

  // ----------------------------------------------------------------------
  // Register and output assertions
  // ----------------------------------------------------------------------
  reset_clear_a: assert property (@(posedge clk_in)
    !rst_n_in |=> state_ff == key_irq_pkg::TRIG_IDLE
      && key_pin_enable_ff == PINS'(`KEY_ENABLE_RESET))
    else $error("reset left a request or an enable");

  enable_write_a: assert property (@(posedge clk_in)
    disable iff (!rst_n_in)
    wr_en |=> key_pin_enable_ff == $past(wdata_in[PINS-1:0]))
    else $error("pin enable write not stored");

  pullup_write_a: assert property (@(posedge clk_in)
    disable iff (!rst_n_in)
    wr_pu |=> port_pullup_enable_ff == $past(wdata_in[PINS-1:0]))
    else $error("pull-up write not stored");

  mode_write_a: assert property (@(posedge clk_in)
    disable iff (!rst_n_in)
    wr_ctl |=> level_mode == $past(wdata_in[`KSC_MODE_BIT]))
    else $error("trigger mode write not stored");

  mask_write_a: assert property (@(posedge clk_in)
    disable iff (!rst_n_in)
    wr_ctl |=> key_irq_mask_ff == $past(wdata_in[`KSC_MASK_BIT]))
    else $error("mask write not stored");

  pullup_force_a: assert property (@(posedge clk_in)
    disable iff (!rst_n_in)
    (pullup_on_out & key_pin_enable_ff) == key_pin_enable_ff)
    else $error("enabled key pin lacks pull-up");

  // Only checked once two clean edges have filled both stages
  sync_delay_a: assert property (@(posedge clk_in)
    disable iff (!rst_n_in)
    ($past(rst_n_in) && $past(rst_n_in, 2))
      |-> sync_level == $past(key_pins_in, 2))
    else $error("pin level not two cycles behind the pin");

  read_idle_a: assert property (@(posedge clk_in)
    disable iff (!rst_n_in)
    !$past(rd_in) |-> rdata_out == '0)
    else $error("read data not zero outside a read");

  mask_gate_a: assert property (@(posedge clk_in)
    disable iff (!rst_n_in)
    key_irq_out == (request && !key_irq_mask_ff))
    else $error("interrupt output not gated by mask");

  masked_quiet_a: assert property (@(posedge clk_in)
    disable iff (!rst_n_in)
    key_irq_mask_ff |-> !key_irq_out)
    else $error("masked request reached the processor");

  idle_quiet_a: assert property (@(posedge clk_in)
    disable iff (!rst_n_in)
    state_ff == key_irq_pkg::TRIG_IDLE |-> !key_irq_out)
    else $error("interrupt raised with no request");

  // ----------------------------------------------------------------------
  // Trigger assertions
  // ----------------------------------------------------------------------
  // Antecedents name mode and state where the result depends on them, so each holds under any legal mix
  // of pins, enables and acknowledges
  fall_latch_a: assert property (@(posedge clk_in)
    disable iff (!rst_n_in)
    fall_event |=> request)
    else $error("fall did not latch request");

  edge_block_a: assert property (@(posedge clk_in)
    disable iff (!rst_n_in)
    (!request && !all_high_ff && !level_mode) |=> !request)
    else $error("request latched while a pin was already low");

  level_hold_a: assert property (@(posedge clk_in)
    disable iff (!rst_n_in)
    (request && level_mode && any_low && $stable(key_pin_enable_ff)
     && !wr_ctl) |=> request)
    else $error("level mode dropped request with pin low");

  ack_clear_a: assert property (@(posedge clk_in)
    disable iff (!rst_n_in)
    (state_ff == key_irq_pkg::TRIG_LATCHED && ack && !fall_event
     && (!level_mode || !any_low)) |=> !request)
    else $error("acknowledge did not clear request");

  ack_write_a: assert property (@(posedge clk_in)
    disable iff (!rst_n_in)
    (ack_wr && !fall_event && state_ff == key_irq_pkg::TRIG_LATCHED
     && !any_low) |=> state_ff == key_irq_pkg::TRIG_IDLE)
    else $error("acknowledge write ignored");

  edge_ack_a: assert property (@(posedge clk_in)
    disable iff (!rst_n_in)
    (!level_mode && state_ff == key_irq_pkg::TRIG_LATCHED && ack
     && !fall_event) |=> state_ff == key_irq_pkg::TRIG_IDLE)
    else $error("edge mode acknowledge kept the request");

  ack_level_a: assert property (@(posedge clk_in)
    disable iff (!rst_n_in)
    (level_mode && state_ff == key_irq_pkg::TRIG_LATCHED && ack
     && any_low) |=> request)
    else $error("level mode cleared with a pin still low");

  hold_release_a: assert property (@(posedge clk_in)
    disable iff (!rst_n_in)
    (state_ff == key_irq_pkg::TRIG_HOLD && !any_low) |=> !request)
    else $error("held request outlived the low pins");

  fresh_fall_a: assert property (@(posedge clk_in)
    disable iff (!rst_n_in)
    (ack && fall_event) |=> state_ff == key_irq_pkg::TRIG_LATCHED)
    else $error("fall during acknowledge was lost");

  vector_fetch_a: assert property (@(posedge clk_in)
    disable iff (!rst_n_in)
    (vector_fetch_in && state_ff == key_irq_pkg::TRIG_LATCHED
     && !fall_event && !any_low) |=> !request)
    else $error("vector fetch did not clear request");

  unacked_keep_a: assert property (@(posedge clk_in)
    disable iff (!rst_n_in)
    (request && !acked_ff && !ack) |=> request)
    else $error("request ended without an acknowledge");

endmodule : key_pin_irq
`default_nettype wire

// >>> sim/key_switch_model.sv
// Key switches on the keyboard pins, with floating lines when no pull-up
`timescale 1ns/100ps
`default_nettype none
module key_switch_model #(
  parameter int PINS = 7
) (
  input wire logic clk_in,
  input wire logic [PINS-1:0] press_in,
  input wire logic [PINS-1:0] pullup_on_in,
  output logic [PINS-1:0] pins_out
);
  // A released line with no pull-up floats; toggling keeps it from
  // looking like a stable level to the detector
  logic [PINS-1:0] float_ff = '0;
  always @(posedge clk_in) begin
    float_ff <= ~float_ff;
  end
  // A closed switch pulls its line low
  assign pins_out = ~press_in & (pullup_on_in | float_ff);
endmodule : key_switch_model
`default_nettype wire

// >>> sim/testbench.sv
// Self-checking bench for the keyboard pin interrupt block
`timescale 1ns/100ps
`default_nettype none
`include "key_irq_defines.svh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin fail_count++; $display("mismatch at %0t got %h exp %h", $time, g, e); end end
module testbench;
  localparam int PINS = `KEY_PINS_DEFAULT;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [`KEY_ADDR_W-1:0] addr = '0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic fetch = 1'b0;
  logic [7:0] rdata;
  logic [7:0] d;
  logic [PINS-1:0] press = '0;
  logic [PINS-1:0] pins;
  logic [PINS-1:0] pullup_on;
  logic key_irq;
  int fail_count = 0;
  int samples_checked = 0;
  int cycles = 0;
  int pm = 0, en = 0, pup = 0, mode = 0, mask = 0, latched = 0, r, b;

  always #25 clk_in = ~clk_in;

  key_pin_irq #(.PINS(PINS)) dut (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd),
    .rdata_out(rdata), .key_pins_in(pins), .vector_fetch_in(fetch),
    .pullup_on_out(pullup_on), .key_irq_out(key_irq));
  key_switch_model #(.PINS(PINS)) switches (.clk_in(clk_in),
    .press_in(press), .pullup_on_in(pullup_on), .pins_out(pins));

  // ----------------------------------------------------------------------
  // Verdict, watchdog and bus cycles
  // ----------------------------------------------------------------------
  task tally_and_finish();
    $display("checked %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : tally_and_finish

  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      tally_and_finish();
    end
  end

  task wr_reg(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk_in);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk_in);
    wr <= 1'b0;
  endtask : wr_reg

  task rd_reg(input logic [3:0] a, output logic [7:0] v);
    @(posedge clk_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_in);
    rd <= 1'b0;
    #1 v = rdata;
  endtask : rd_reg

  // ----------------------------------------------------------------------
  // Reference model: a fall latches only when all enabled pins were high
  // ----------------------------------------------------------------------
  function void step(int np, int ne);
    if ((pm & en) == 0 && (np & ne) != 0) latched = 1;
    pm = np;
    en = ne;
  endfunction : step

  task check();
    int raw;
    repeat (6) @(posedge clk_in);
    raw = latched | (mode != 0 && (pm & en) != 0);
    rd_reg(`KEY_STATUS_CONTROL_OFS, d);
    `CHK(d[`KSC_REQ_BIT], raw[0])
    `CHK(key_irq, raw[0] & (mask == 0))
    `CHK(pullup_on, PINS'(pup | en))
    rd_reg(`KEY_PIN_LEVEL_OFS, d);
    `CHK(d[PINS-1:0] & PINS'(en), PINS'(~pm & en))
  endtask : check

  initial begin
    void'($urandom(32'h835AA0D3));
    repeat (6) @(posedge clk_in);
    rst_n_in <= 1'b1;
    rd_reg(`KEY_PIN_ENABLE_OFS, d);
    `CHK(d, `KEY_ENABLE_RESET)
    rd_reg(`PORT_A_PULLUP_OFS, d);
    `CHK(d, `KEY_PULLUP_RESET)
    rd_reg(4'h9, d);
    `CHK(d, 8'h00)
    rd_reg(`KEY_STATUS_CONTROL_OFS, d);
    `CHK(d, 8'h00)
    for (int m = 0; m < 2; m++) begin
      mode = m;
      mask = 0;
      latched = 0;
      wr_reg(`KEY_STATUS_CONTROL_OFS, 8'(4 | m));
      for (int i = 0; i < 80; i++) begin
        r = $urandom % 6;
        b = 1 << ($urandom % PINS);
        case (r)
          0, 1: begin
            step(pm ^ b, en);
            @(posedge clk_in);
            press <= PINS'(pm);
          end
          2: begin
            // Pull-up first, so a newly enabled idle pin reads high
            if ((en & b) == 0) begin
              pup |= b;
              wr_reg(`PORT_A_PULLUP_OFS, 8'(pup));
            end
            step(pm, en ^ b);
            wr_reg(`KEY_PIN_ENABLE_OFS, 8'(en));
          end
          3: begin
            latched = 0;
            wr_reg(`KEY_STATUS_CONTROL_OFS, 8'(4 | mask << 1 | mode));
          end
          4: begin
            latched = 0;
            @(posedge clk_in);
            fetch <= 1'b1;
            @(posedge clk_in);
            fetch <= 1'b0;
          end
          default: begin
            mask = $urandom % 2;
            pup = $urandom & 127 & ~en;
            wr_reg(`KEY_STATUS_CONTROL_OFS, 8'(mask << 1 | mode));
            wr_reg(`PORT_A_PULLUP_OFS, 8'(pup));
          end
        endcase
        check();
      end
      step(0, en);
      @(posedge clk_in);
      press <= '0;
      check();
    end
    // A reset in mid-run must drop a latched request and every enable
    step(pm, 1);
    wr_reg(`KEY_PIN_ENABLE_OFS, 8'h01);
    @(posedge clk_in);
    step(1, en);
    press <= PINS'(1);
    check();
    @(posedge clk_in);
    press <= '0;
    rst_n_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    rst_n_in <= 1'b1;
    step(0, 0);
    latched = 0;
    pup = 0;
    mask = 0;
    mode = 0;
    check();
    rd_reg(`KEY_PIN_ENABLE_OFS, d);
    `CHK(d, `KEY_ENABLE_RESET)
    tally_and_finish();
  end
endmodule : testbench
`default_nettype wire
